//--- logic/gcp_consts.vh
// Constants for the per-axis guide correction policy block.
// Assumes fixed-point formats: drift and tolerance in 1/100 pixel, times in 10 ms units.
`ifndef GCP_CONSTS_VH
`define GCP_CONSTS_VH
// Register indices on the plain register port
`define GCP_A_CTRL       4'h0
`define GCP_A_RA_TOL     4'h1
`define GCP_A_RA_AGGR    4'h2
`define GCP_A_RA_AVG     4'h3
`define GCP_A_DEC_TOL    4'h4
`define GCP_A_DEC_AGGR   4'h5
`define GCP_A_DEC_AVG    4'h6
`define GCP_A_BL_CTRL    4'h7
`define GCP_A_BL_TIME    4'h8
`define GCP_A_BL_APPLY   4'h9
`define GCP_A_STATUS     4'ha
`define GCP_A_STAR_POS   4'hb
`define GCP_A_WIDTH      4'hc
`define GCP_A_BL_CMD     4'hd
// Limits, in register units
`define GCP_TOL_MIN      16'd1
`define GCP_TOL_MAX      16'd999
`define GCP_AGGR_MIN     8'd1
`define GCP_AGGR_MAX     8'd200
`define GCP_AVG_MAX      8'd99
`define GCP_BLT_MAX      16'd9999
`define GCP_APPLY_MAX    8'd99
`define GCP_EMERG_MIN    16'd100
`define GCP_EMERG_MULT   18'd3
// Reset values
`define GCP_TOL_RST      16'd50
`define GCP_AGGR_RST     8'd100
`define GCP_AVG_RST      8'd1
// Policies and suppression codes
`define GCP_POL_ZERO     2'd0
`define GCP_POL_BORDER   2'd1
`define GCP_POL_ALWAYS   2'd2
`define GCP_SUP_NONE     2'd0
`define GCP_SUP_UP       2'd1
`define GCP_SUP_DOWN     2'd2
// Width marker for no star
`define GCP_WIDTH_UNK    16'hffff
`endif

//--- logic/gcp_axis.v
// One guiding axis: averages drift and computes a signed correction length.
// Assumes drift samples arrive as one-cycle strobes with the frame's drift.
`timescale 1ns/100ps
`default_nettype none
`include "gcp_consts.vh"
module gcp_axis (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               frame_vld,
  input  wire signed [15:0] drift,
  input  wire        [15:0] tol,
  input  wire        [7:0]  aggr,
  input  wire        [7:0]  avg_n,
  input  wire        [1:0]  policy,
  output reg                corr_vld_r,
  output reg  signed [23:0] corr_len_r,
  output reg                emerg_r
);
  reg signed [23:0] acc_r;
  reg        [7:0]  cnt_r;
  reg signed [23:0] sum;
  reg signed [23:0] avg;
  reg        [23:0] mag;
  reg signed [23:0] base;
  reg               emerg;
  reg               done;

  // Average and decide; scaling by aggr happens at the output register
  always @* begin
    sum   = acc_r + {{8{drift[15]}}, drift};
    mag   = drift[15] ? -{{8{drift[15]}}, drift} : {8'h00, drift};
    emerg = (mag > {6'h00, tol, 2'b00} - {8'h00, tol}) &&
            (mag >= {8'h00, `GCP_EMERG_MIN});
    done  = emerg || (cnt_r + 8'd1 >= avg_n);
    avg   = emerg ? {{8{drift[15]}}, drift} : sum / $signed({16'h0000, avg_n});
    mag   = avg[23] ? -avg : avg;
    base  = 24'sd0;
    if (mag > {8'h00, tol}) begin
      if (policy == `GCP_POL_BORDER)
        base = avg[23] ? avg + $signed({8'h00, tol}) : avg - $signed({8'h00, tol});
      else
        base = avg;
    end else if (policy == `GCP_POL_ALWAYS) begin
      base = avg;
    end
  end

  // Accumulator and output registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r      <= 24'sd0;
      cnt_r      <= 8'h00;
      corr_vld_r <= 1'b0;
      corr_len_r <= 24'sd0;
      emerg_r    <= 1'b0;
    end else begin
      corr_vld_r <= 1'b0;
      emerg_r    <= 1'b0;
      if (frame_vld && avg_n != 8'h00) begin
        if (done) begin
          acc_r      <= 24'sd0;
          cnt_r      <= 8'h00;
          corr_vld_r <= 1'b1;
          emerg_r    <= emerg;
          corr_len_r <= (base * $signed({16'h0000, aggr})) / 24'sd100;
        end else begin
          acc_r <= sum;
          cnt_r <= cnt_r + 8'd1;
        end
      end
    end
  end
endmodule // gcp_axis
`default_nettype wire

//--- logic/gcp_track.v
// Star tracking point, partial search radius and width report.
// Assumes the centroid engine reports each frame result as a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
`include "gcp_consts.vh"
module gcp_track (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        method_new,
  input  wire        partial,
  input  wire        cam_on,
  input  wire        res_vld,
  input  wire        res_found,
  input  wire [15:0] res_pos,
  input  wire [15:0] res_width,
  input  wire [7:0]  ring_hits,
  input  wire        ring_vld,
  input  wire        pick_vld,
  input  wire [15:0] pick_pos,
  output reg  [15:0] seed_pos_r,
  output reg         full_win_r,
  output reg  [7:0]  radius_r,
  output reg         search_done_r,
  output reg  [15:0] width_r
);
  // Seed, ring growth and width
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seed_pos_r    <= 16'h0000;
      full_win_r    <= 1'b1;
      radius_r      <= 8'h00;
      search_done_r <= 1'b0;
      width_r       <= `GCP_WIDTH_UNK;
    end else begin
      full_win_r <= !method_new && !partial;
      if (pick_vld)
        seed_pos_r <= pick_pos;
      else if (res_vld && res_found && cam_on)
        seed_pos_r <= res_pos;
      if (res_vld) begin
        radius_r      <= 8'h00;
        search_done_r <= 1'b0;
        if (method_new)
          width_r <= res_found ? res_width : `GCP_WIDTH_UNK;
      end else if (ring_vld && !search_done_r) begin
        if (ring_hits == 8'h00)
          search_done_r <= 1'b1;
        else
          radius_r <= radius_r + 8'd1;
      end
    end
  end
endmodule // gcp_track
`default_nettype wire

//--- logic/gcp_top.v
// Guide correction policy: per-axis decision, DEC backlash handling, tracking.
// Assumes a plain register port and synchronous camera and mount handshakes.
// Functional notes
// - Tolerance band half-width 0.01 to 9.99 px
// - Correction scaled by aggressivity 1 to 200%
// - Policy 0: none inside, correct to zero
// - Policy 1: correct only to tolerance border
// - Policy 2: also correct inside band
// - Large drift bypasses averaging, always on
// - Backlash settings only while DEC enabled
// - DEC suppress none, up or down
// - Compensation enabled overrides direction suppression
// - Reversal adds time times apply percent
// - Backlash measure needs idle and calibration
// - Average 1 to 99 frames per correction
// - DEC count zero disables DEC corrections
// - Newer method always partial, no threshold
// - Full window uses whole image
// - Partial search grows octagons from last position
// - Camera restart resumes from last position
// - Newer method reports width or unknown
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "gcp_consts.vh"
module gcp_top (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        frame_vld,
  input  wire [15:0] drift_ra,
  input  wire [15:0] drift_dec,
  input  wire        guiding,
  input  wire        cal_valid,
  input  wire        res_vld,
  input  wire        res_found,
  input  wire [15:0] res_pos,
  input  wire [15:0] res_width,
  input  wire [7:0]  ring_hits,
  input  wire        ring_vld,
  input  wire        bl_meas_done,
  input  wire        bl_meas_ok,
  input  wire [15:0] bl_meas_time,
  output reg  [31:0] reg_rdata_r,
  output reg         ra_vld_r,
  output reg  [23:0] ra_len_r,
  output reg         dec_vld_r,
  output reg  [23:0] dec_len_r,
  output reg         bl_meas_start_r,
  output reg         bl_meas_abort_r,
  output reg  [15:0] seed_pos_r,
  output reg         full_win_r,
  output reg  [7:0]  radius_r,
  output reg         search_done_r
);
  // ---
  // Configuration registers
  // ---
  reg [1:0]  policy_r;
  reg        method_new_r;
  reg        partial_r;
  reg        cam_on_r;
  reg [15:0] ra_tol_r;
  reg [7:0]  ra_aggr_r;
  reg [7:0]  ra_avg_r;
  reg [15:0] dec_tol_r;
  reg [7:0]  dec_aggr_r;
  reg [7:0]  dec_avg_r;
  reg [1:0]  sup_r;
  reg        comp_r;
  reg [15:0] bl_time_r;
  reg [7:0]  bl_apply_r;
  reg        bl_busy_r;
  reg        bl_err_r;
  reg        last_dir_r;
  reg        dir_known_r;
  reg        pick_vld_r;
  reg [15:0] pick_pos_r;
  wire       dec_en = (dec_avg_r != 8'h00);

  // Clamp helpers keep each setting inside its legal range
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [7:0] clamp8;
    input [31:0] v;
    input [7:0]  lo;
    input [7:0]  hi;
    begin
      clamp8 = (v < {24'h0, lo}) ? lo : ((v > {24'h0, hi}) ? hi : v[7:0]);
    end
  endfunction

  // ---
  // Per-axis engines
  // ---
  wire               ra_cv;
  wire signed [23:0] ra_cl;
  wire               dec_cv;
  wire signed [23:0] dec_cl;
  wire [15:0]        trk_seed;
  wire               trk_full;
  wire [7:0]         trk_rad;
  wire               trk_done;
  wire [15:0]        trk_width;

  // RA axis with its own parameter set
  gcp_axis u_ra (
    .clk        (clk),
    .reset_n    (reset_n),
    .frame_vld  (frame_vld),
    .drift      (drift_ra),
    .tol        (ra_tol_r),
    .aggr       (ra_aggr_r),
    .avg_n      (ra_avg_r),
    .policy     (policy_r),
    .corr_vld_r (ra_cv),
    .corr_len_r (ra_cl),
    .emerg_r    ()
  );

  // DEC axis with its own parameter set
  gcp_axis u_dec (
    .clk        (clk),
    .reset_n    (reset_n),
    .frame_vld  (frame_vld),
    .drift      (drift_dec),
    .tol        (dec_tol_r),
    .aggr       (dec_aggr_r),
    .avg_n      (dec_avg_r),
    .policy     (policy_r),
    .corr_vld_r (dec_cv),
    .corr_len_r (dec_cl),
    .emerg_r    ()
  );

  // Star tracking
  gcp_track u_trk (
    .clk           (clk),
    .reset_n       (reset_n),
    .method_new    (method_new_r),
    .partial       (partial_r),
    .cam_on        (cam_on_r),
    .res_vld       (res_vld),
    .res_found     (res_found),
    .res_pos       (res_pos),
    .res_width     (res_width),
    .ring_hits     (ring_hits),
    .ring_vld      (ring_vld),
    .pick_vld      (pick_vld_r),
    .pick_pos      (pick_pos_r),
    .seed_pos_r    (trk_seed),
    .full_win_r    (trk_full),
    .radius_r      (trk_rad),
    .search_done_r (trk_done),
    .width_r       (trk_width)
  );

  // ---
  // DEC direction handling
  // ---
  reg        dec_up;
  reg        sup_eff_up;
  reg        sup_eff_dn;
  reg [31:0] bl_add;
  reg [23:0] dec_out;
  reg        dec_pass;

  // Suppression, reversal compensation and final DEC length
  always @* begin
    dec_up     = !dec_cl[23];
    sup_eff_up = !comp_r && (sup_r == `GCP_SUP_UP);
    sup_eff_dn = !comp_r && (sup_r == `GCP_SUP_DOWN);
    bl_add     = ({16'h0000, bl_time_r} * {24'h000000, bl_apply_r}) / 32'd100;
    dec_out    = dec_cl;
    if (comp_r && dir_known_r && (dec_up != last_dir_r) && dec_cl != 24'sd0) begin
      if (dec_up)
        dec_out = dec_cl + bl_add[23:0];
      else
        dec_out = dec_cl - bl_add[23:0];
    end
    dec_pass = dec_cv && dec_en && (dec_cl != 24'sd0) &&
               !(dec_up && sup_eff_up) && !(!dec_up && sup_eff_dn);
  end

  // Correction outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ra_vld_r    <= 1'b0;
      ra_len_r    <= 24'h000000;
      dec_vld_r   <= 1'b0;
      dec_len_r   <= 24'h000000;
      last_dir_r  <= 1'b0;
      dir_known_r <= 1'b0;
    end else begin
      ra_vld_r  <= ra_cv && (ra_cl != 24'sd0);
      ra_len_r  <= ra_cl;
      dec_vld_r <= dec_pass;
      dec_len_r <= dec_out;
      if (dec_pass) begin
        last_dir_r  <= dec_up;
        dir_known_r <= 1'b1;
      end
    end
  end

  // Tracking outputs mirrored from registers of the tracker
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seed_pos_r    <= 16'h0000;
      full_win_r    <= 1'b1;
      radius_r      <= 8'h00;
      search_done_r <= 1'b0;
    end else begin
      seed_pos_r    <= trk_seed;
      full_win_r    <= trk_full;
      radius_r      <= trk_rad;
      search_done_r <= trk_done;
    end
  end

  // ---
  // Register writes and backlash measurement
  // ---
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      policy_r        <= `GCP_POL_ZERO;
      method_new_r    <= 1'b0;
      partial_r       <= 1'b0;
      cam_on_r        <= 1'b1;
      ra_tol_r        <= `GCP_TOL_RST;
      ra_aggr_r       <= `GCP_AGGR_RST;
      ra_avg_r        <= `GCP_AVG_RST;
      dec_tol_r       <= `GCP_TOL_RST;
      dec_aggr_r      <= `GCP_AGGR_RST;
      dec_avg_r       <= `GCP_AVG_RST;
      sup_r           <= `GCP_SUP_NONE;
      comp_r          <= 1'b0;
      bl_time_r       <= 16'h0000;
      bl_apply_r      <= 8'h00;
      bl_busy_r       <= 1'b0;
      bl_err_r        <= 1'b0;
      bl_meas_start_r <= 1'b0;
      bl_meas_abort_r <= 1'b0;
      pick_vld_r      <= 1'b0;
      pick_pos_r      <= 16'h0000;
    end else begin
      bl_meas_start_r <= 1'b0;
      bl_meas_abort_r <= 1'b0;
      pick_vld_r      <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `GCP_A_CTRL: begin
            policy_r     <= (reg_wdata[1:0] > `GCP_POL_ALWAYS) ? `GCP_POL_ALWAYS
                                                               : reg_wdata[1:0];
            method_new_r <= reg_wdata[4];
            partial_r    <= reg_wdata[5];
            cam_on_r     <= reg_wdata[6];
          end
          `GCP_A_RA_TOL:   ra_tol_r   <= clamp16(reg_wdata[15:0], `GCP_TOL_MIN, `GCP_TOL_MAX);
          `GCP_A_RA_AGGR:  ra_aggr_r  <= clamp8(reg_wdata, `GCP_AGGR_MIN, `GCP_AGGR_MAX);
          `GCP_A_RA_AVG:   ra_avg_r   <= clamp8(reg_wdata, 8'd1, `GCP_AVG_MAX);
          `GCP_A_DEC_TOL:  dec_tol_r  <= clamp16(reg_wdata[15:0], `GCP_TOL_MIN, `GCP_TOL_MAX);
          `GCP_A_DEC_AGGR: dec_aggr_r <= clamp8(reg_wdata, `GCP_AGGR_MIN, `GCP_AGGR_MAX);
          `GCP_A_DEC_AVG:  dec_avg_r  <= clamp8(reg_wdata, 8'd0, `GCP_AVG_MAX);
          `GCP_A_BL_CTRL: if (dec_en) begin
            sup_r  <= (reg_wdata[1:0] == 2'd3) ? `GCP_SUP_NONE : reg_wdata[1:0];
            comp_r <= reg_wdata[4];
          end
          `GCP_A_BL_TIME:  if (dec_en) bl_time_r <= clamp16(reg_wdata[15:0], 16'd0, `GCP_BLT_MAX);
          `GCP_A_BL_APPLY: if (dec_en) bl_apply_r <= clamp8(reg_wdata, 8'd0, `GCP_APPLY_MAX);
          `GCP_A_STAR_POS: begin
            pick_vld_r <= 1'b1;
            pick_pos_r <= reg_wdata[15:0];
          end
          `GCP_A_BL_CMD: begin
            if (reg_wdata[0] && !bl_busy_r && !guiding && cal_valid && dec_en) begin
              bl_busy_r       <= 1'b1;
              bl_err_r        <= 1'b0;
              bl_meas_start_r <= 1'b1;
            end else if (reg_wdata[1] && bl_busy_r) begin
              bl_busy_r       <= 1'b0;
              bl_meas_abort_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (bl_busy_r && bl_meas_done) begin
        bl_busy_r <= 1'b0;
        bl_err_r  <= !bl_meas_ok;
        if (bl_meas_ok)
          bl_time_r <= clamp16(bl_meas_time, 16'd0, `GCP_BLT_MAX);
      end
    end
  end

  // ---
  // Register reads, data in the cycle after the strobe
  // ---
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `GCP_A_CTRL:     reg_rdata_r <= {25'h0, cam_on_r, partial_r | method_new_r,
                                         method_new_r, 2'h0, policy_r};
        `GCP_A_RA_TOL:   reg_rdata_r <= {16'h0, ra_tol_r};
        `GCP_A_RA_AGGR:  reg_rdata_r <= {24'h0, ra_aggr_r};
        `GCP_A_RA_AVG:   reg_rdata_r <= {24'h0, ra_avg_r};
        `GCP_A_DEC_TOL:  reg_rdata_r <= {16'h0, dec_tol_r};
        `GCP_A_DEC_AGGR: reg_rdata_r <= {24'h0, dec_aggr_r};
        `GCP_A_DEC_AVG:  reg_rdata_r <= {24'h0, dec_avg_r};
        `GCP_A_BL_CTRL:  reg_rdata_r <= {27'h0, comp_r, 2'h0,
                                         comp_r ? `GCP_SUP_NONE : sup_r};
        `GCP_A_BL_TIME:  reg_rdata_r <= {16'h0, bl_time_r};
        `GCP_A_BL_APPLY: reg_rdata_r <= {24'h0, bl_apply_r};
        `GCP_A_STATUS:   reg_rdata_r <= {26'h0, trk_done, trk_full, dec_en,
                                         bl_err_r, bl_busy_r, dir_known_r};
        `GCP_A_STAR_POS: reg_rdata_r <= {16'h0, trk_seed};
        `GCP_A_WIDTH:    reg_rdata_r <= {16'h0, trk_width};
        default:         reg_rdata_r <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_r <= 32'h00000000;
    end
  end
endmodule // gcp_top
`default_nettype wire

//--- testbench/gcp_top_assertions.sv
// Checker for gcp_top: relations between its ports over time.
// Assumes a bind into gcp_top; settings shadowed from register writes.
`timescale 1ns/100ps
`default_nettype none
module gcp_top_assertions (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        frame_vld,
  input wire logic [15:0] drift_ra,
  input wire logic        guiding,
  input wire logic        cal_valid,
  input wire logic        ra_vld_r,
  input wire logic [23:0] ra_len_r,
  input wire logic        dec_vld_r,
  input wire logic [23:0] dec_len_r,
  input wire logic        bl_meas_start_r,
  input wire logic        bl_meas_abort_r,
  input wire logic        full_win_r
);
  logic [15:0] tol_r;
  logic [7:0]  aggr_r;
  logic [1:0]  sup_r;
  logic        comp_r;
  logic        dec_off_r;
  logic        new_r;
  wire  [15:0] mag = drift_ra[15] ? -drift_ra : drift_ra;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---
  // Settings shadow
  // ---
  // Mirror of the settings the relations depend on
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tol_r <= 16'h32;
      aggr_r <= 8'h64;
      sup_r <= 2'h0;
      comp_r <= 1'b0;
      dec_off_r <= 1'b0;
      new_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h1) tol_r <= reg_wdata[15:0];
      if (reg_addr == 4'h2) aggr_r <= reg_wdata[7:0];
      if (reg_addr == 4'h6) dec_off_r <= (reg_wdata == 32'h0);
      if (reg_addr == 4'h0) new_r <= reg_wdata[4];
      if (reg_addr == 4'h7 && !dec_off_r) begin
        sup_r <= reg_wdata[1:0];
        comp_r <= reg_wdata[4];
      end
    end
  end
  AST_RA_AFTER_FRAME: assert property (ra_vld_r |-> $past(frame_vld, 2))
    else $error("RA pulse without frame");
  AST_DEC_AFTER_FRAME: assert property (dec_vld_r |-> $past(frame_vld, 2))
    else $error("DEC pulse without frame");
  AST_NO_EMPTY_PULSE: assert property (ra_vld_r |-> ra_len_r != 24'h0)
    else $error("RA correction of zero length");
  AST_EMERGENCY: assert property (frame_vld && {2'h0, mag} > 18'h3 * {2'h0, tol_r}
    && mag >= 16'h64 && aggr_r >= 8'h64 |-> ##2 ra_vld_r)
    else $error("No emergency RA pulse");
  AST_DEC_OFF: assert property (dec_off_r |-> !dec_vld_r)
    else $error("DEC pulse while disabled");
  AST_SUP_UP: assert property (!comp_r && sup_r == 2'h1 && dec_vld_r |-> dec_len_r[23])
    else $error("Suppressed up correction issued");
  AST_SUP_DOWN: assert property (!comp_r && sup_r == 2'h2 && dec_vld_r |-> !dec_len_r[23])
    else $error("Suppressed down correction issued");
  AST_BL_START: assert property (bl_meas_start_r |-> $past(reg_wr && reg_addr == 4'hd
    && reg_wdata[0] && !guiding && cal_valid))
    else $error("Backlash start not allowed");
  AST_BL_ABORT: assert property (bl_meas_abort_r |-> $past(reg_wr && reg_addr == 4'hd
    && reg_wdata[1]))
    else $error("Backlash abort without a command");
  AST_NEW_PARTIAL: assert property (new_r && $past(new_r, 3) |-> !full_win_r)
    else $error("Newer method in full window");
endmodule // gcp_top_assertions
bind gcp_top gcp_top_assertions gcp_top_assertions_i (.*);
`default_nettype wire

//--- testbench/gcp_far_model.sv
// Far-side model: camera centroid results and the mount's backlash run.
// Assumes one-cycle request strobes from the bench and from the block.
`timescale 1ns/100ps
`default_nettype none
module gcp_far_model #(
  parameter logic [15:0] MEAS_TIME = 16'h04d2,
  parameter int          MEAS_CYC  = 20
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        bl_meas_start_r,
  input  wire logic        bl_meas_abort_r,
  input  wire logic        cam_req,
  input  wire logic        cam_found,
  input  wire logic [15:0] cam_width,
  output logic             res_vld,
  output logic             res_found,
  output logic [15:0]      res_pos,
  output logic [15:0]      res_width,
  output logic             ring_vld,
  output logic [7:0]       ring_hits,
  output logic             bl_meas_done,
  output logic             bl_meas_ok,
  output logic [15:0]      bl_meas_time
);
  logic [2:0]  st_r;
  logic [15:0] w_r;
  logic [15:0] junk_r;
  logic        f_r;
  logic        ok_r;
  int          cnt_r;
  // ---
  // Camera and mount
  // ---
  // Frame: a ring with hits, an empty outer ring, then the centroid result
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= 3'h0;
      cnt_r <= 0;
      bl_meas_done <= 1'b0;
      junk_r <= 16'h5a5a;
    end else begin
      junk_r <= ~junk_r + 16'h1;
      st_r <= {st_r[1:0], cam_req};
      f_r <= cam_req ? cam_found : f_r;
      w_r <= cam_req ? cam_width : w_r;
      bl_meas_done <= 1'b0;
      if (bl_meas_start_r) cnt_r <= MEAS_CYC;
      else if (bl_meas_abort_r && cnt_r != 0) begin
        cnt_r <= 0;
        bl_meas_done <= 1'b1;
        ok_r <= 1'b0;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
        bl_meas_done <= (cnt_r == 1);
        ok_r <= 1'b1;
      end
    end
  end
  // Lines outside their valid cycle carry a changing pattern
  assign ring_vld = st_r[0] | st_r[1];
  assign ring_hits = st_r[0] ? 8'h03 : (st_r[1] ? 8'h00 : junk_r[7:0]);
  assign res_vld = st_r[2];
  assign res_found = st_r[2] ? f_r : junk_r[0];
  assign res_pos = st_r[2] ? 16'h0a0b : junk_r;
  assign res_width = st_r[2] ? w_r : junk_r;
  assign bl_meas_ok = bl_meas_done ? ok_r : junk_r[1];
  assign bl_meas_time = bl_meas_done ? MEAS_TIME : junk_r;
endmodule // gcp_far_model
`default_nettype wire

//--- testbench/tb_top.sv
// Testbench for gcp_top: settings, corrections, backlash run and width report.
// Assumes gcp_far_model in place of camera and mount.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [24:0] NONE = 25'h0;
  logic        clk, reset_n, reg_wr, reg_rd, frame_vld, guiding, cal_valid, rd_f;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r;
  logic [15:0] drift_ra, drift_dec, res_pos, res_width, bl_meas_time, seed_pos_r, cam_width;
  logic [7:0]  ring_hits, radius_r;
  logic [23:0] ra_len_r, dec_len_r;
  logic        res_vld, res_found, ring_vld, bl_meas_done, bl_meas_ok, ra_vld_r, dec_vld_r;
  logic        bl_meas_start_r, bl_meas_abort_r, full_win_r, search_done_r, cam_req, cam_found;
  logic [31:0] rd_q[$];
  logic [23:0] ra_q[$], dec_q[$];
  int          errors, comparisons, n, d, e, a, pol;
  logic [3:0]  ta[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'he};
  int          tv[8] = '{50, 100, 1, 50, 100, 1, 65535, 0};
  logic [3:0]  ca[5] = '{4'h4, 4'h4, 4'h5, 4'h5, 4'h3};
  int          cw[5] = '{0, 1000, 300, 0, 150};
  int          ce[5] = '{1, 999, 200, 1, 99};
  gcp_top gcp_top_i (.*);
  gcp_far_model gcp_far_model_i (.*);
  // ---
  // Checking and report
  // ---
  always #5 clk = ~clk;
  task automatic final_report;
    errors += ra_q.size() + dec_q.size() + rd_q.size();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %0t read exp %h got %h", $time, ex, got);
    end
  endtask
  task automatic chk_len(input logic [23:0] ex, input logic [23:0] got);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %0t length exp %h got %h", $time, ex, got);
    end
  endtask
  // Watcher: each result against the oldest note of its kind
  always @(posedge clk) rd_f <= reg_rd;
  always @(negedge clk) begin
    if (rd_f === 1'b1) chk_rd(rd_q.pop_front(), reg_rdata_r);
    if (search_done_r === 1'b1) chk_rd(rd_q.pop_front(), {24'h0, radius_r});
    if (ra_vld_r === 1'b1) chk_len(ra_q.size() ? ra_q.pop_front() : 24'bx, ra_len_r);
    if (dec_vld_r === 1'b1) chk_len(dec_q.size() ? dec_q.pop_front() : 24'bx, dec_len_r);
  end
  // ---
  // Drivers
  // ---
  function automatic logic [24:0] ex(input int v);
    return {1'b1, v[23:0]};
  endfunction
  // Expected correction: issued flag, then length
  function automatic logic [24:0] exp_len(input int dr, tl, ag, pl);
    int v;
    v = (dr <= tl && dr >= -tl && pl != 2) ? 0 : pl == 1 ? (dr > 0 ? dr - tl : dr + tl) : dr;
    v = v * ag / 100;
    return {v != 0, v[23:0]};
  endfunction
  task automatic wr(input logic [3:0] ad, input int v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input int v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    rd_q.push_back(v);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic frame(input int dr, input int dd, input logic [24:0] er, input logic [24:0] ed);
    @(posedge clk);
    frame_vld <= 1'b1;
    drift_ra <= dr[15:0];
    drift_dec <= dd[15:0];
    if (er[24]) ra_q.push_back(er[23:0]);
    if (ed[24]) dec_q.push_back(ed[23:0]);
    @(posedge clk);
    frame_vld <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic cam(input logic f, input logic [15:0] w);
    @(posedge clk);
    cam_req <= 1'b1;
    cam_found <= f;
    cam_width <= w;
    rd_q.push_back(32'h1);
    @(posedge clk);
    cam_req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_done;
    for (n = 0; n < 100 && bl_meas_done !== 1'b1; n++) @(posedge clk);
    if (n == 100) begin
      errors++;
      final_report;
    end
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    {clk, reset_n, reg_wr, reg_rd, frame_vld, guiding, cal_valid, cam_req, cam_found} = '0;
    {reg_addr, reg_wdata, drift_ra, drift_dec, cam_width} = '0;
    void'($urandom(32'hb926));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (n = 0; n < 8; n++) rd(ta[n], tv[n]);
    chk_rd(32'h1, {31'h0, full_win_r});
    for (n = 0; n < 5; n++) begin
      wr(ca[n], cw[n]);
      rd(ca[n], ce[n]);
    end
    wr(4'h4, 20);
    wr(4'h5, 100);
    wr(4'h3, 1);
    // Random drift under every policy, both axes at once
    for (pol = 0; pol < 3; pol++) begin
      wr(4'h0, 32'h40 | pol);
      for (n = 0; n < 12; n++) begin
        a = $urandom_range(200, 1);
        d = $urandom_range(298) - 149;
        e = $urandom_range(118) - 59;
        if (d == 50 || d == -50) d = 0;
        if (e == 20 || e == -20) e = 0;
        wr(4'h2, a);
        frame(d, e, exp_len(d, 50, a, pol), exp_len(e, 20, 100, pol));
      end
    end
    wr(4'h0, 32'h60);
    wr(4'h2, 100);
    wr(4'h3, 3);
    frame(60, 0, NONE, NONE);
    chk_rd(32'h0, {31'h0, full_win_r});
    frame(80, 0, NONE, NONE);
    frame(100, 0, ex(80), NONE);
    frame(40, 0, NONE, NONE);
    frame(200, 0, ex(200), NONE);
    wr(4'h3, 1);
    wr(4'h7, 1);
    frame(0, 100, NONE, NONE);
    frame(0, -100, NONE, ex(-100));
    wr(4'h7, 2);
    frame(0, 100, NONE, ex(100));
    frame(0, -100, NONE, NONE);
    wr(4'h8, 200);
    wr(4'h9, 50);
    wr(4'h7, 32'h11);
    rd(4'h7, 32'h10);
    frame(0, 100, NONE, ex(100));
    frame(0, -100, NONE, ex(-200));
    wr(4'h6, 0);
    rd(4'h6, 0);
    wr(4'h8, 555);
    rd(4'h8, 200);
    frame(0, 300, NONE, NONE);
    wr(4'h6, 1);
    guiding <= 1'b1;
    cal_valid <= 1'b1;
    wr(4'hd, 1);
    guiding <= 1'b0;
    cal_valid <= 1'b0;
    wr(4'hd, 1);
    repeat (30) @(posedge clk);
    rd(4'h8, 200);
    cal_valid <= 1'b1;
    wr(4'hd, 1);
    wait_done;
    rd(4'h8, 1234);
    wr(4'hd, 1);
    wr(4'hd, 2);
    wait_done;
    rd(4'h8, 1234);
    wr(4'h0, 32'h50);
    cam(1'b1, 16'h0123);
    rd(4'hc, 32'h0123);
    cam(1'b0, 16'h0456);
    rd(4'hc, 32'hffff);
    wr(4'h0, 32'h10);
    wr(4'h0, 32'h50);
    rd(4'hb, 32'h0a0b);
    chk_rd({16'h0a0b, 16'h0}, {seed_pos_r, 15'h0, full_win_r});
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
